// >>> bench/host_bus_model.sv
`timescale 1ns/1ns
module host_bus_model (
  input  wire         i_clk_sys,
  input  wire         i_waitrequest,
  input  wire  [31:0] i_readdata,
  output logic [7:0]  o_address = 8'h00,
  output logic        o_read = 1'h0,
  output logic        o_write = 1'h0,
  output logic [31:0] o_writedata = 32'h0
);
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v, output logic [31:0] q);
    @(posedge i_clk_sys);
    o_address <= a;
    o_read <= !w;
    o_write <= w;
    o_writedata <= v;
    do @(posedge i_clk_sys); while (i_waitrequest !== 1'h0);
    q = i_readdata;
    o_read <= 1'h0;
    o_write <= 1'h0;
    o_writedata <= ~v; // Released data must not look valid
  endtask
endmodule // host_bus_model

// >>> bench/relay_command_queue_props.sv
`timescale 1ns/1ns
module relay_command_queue_props (
  input wire       i_clk_sys,
  input wire       i_nrst,
  input wire       i_read,
  input wire       i_write,
  input wire       o_waitrequest,
  input wire       o_irq,
  input wire [3:0] o_row_drive,
  input wire [3:0] o_col_close,
  input wire [3:0] o_col_open,
  input wire       o_driver_power_on
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  chk_ack_one: assert property ($fell(o_waitrequest) |=> o_waitrequest) else $error("long ack");
  chk_ack_take: assert property ($rose(i_read | i_write) |=> $fell(o_waitrequest)) else $error("late ack");
  chk_ack_idle: assert property (!(i_read | i_write) && o_waitrequest |=> o_waitrequest) else $error("stray ack");
  chk_pwr_gate: assert property ((!o_driver_power_on) [*2] |-> (o_row_drive | o_col_close | o_col_open) == 4'h0)
    else $error("unpowered drive");
  chk_row_onehot: assert property ($onehot0(o_row_drive)) else $error("two rows");
  chk_col_split: assert property ((o_col_close & o_col_open) == 4'h0) else $error("open and close");
  chk_irq_quiet: assert property (o_irq |-> o_row_drive == 4'h0) else $error("irq while driving");
  chk_drive_hold: assert property ($rose(|o_row_drive) |=> $stable(o_row_drive) [*4])
    else $error("short drive");
  cover property ($rose(o_irq));
  cover property ($rose(|o_row_drive));
  cover property (i_write && !o_waitrequest);
endmodule // relay_command_queue_props
bind relay_command_queue relay_command_queue_props chk_u (.i_clk_sys, .i_nrst, .i_read, .i_write, .o_waitrequest,
  .o_irq, .o_row_drive, .o_col_close, .o_col_open, .o_driver_power_on);

// >>> bench/relay_command_queue_tb.sv
`timescale 1ns/1ns
module relay_command_queue_tb;
  logic        i_clk_sys = 1'h0;
  logic        i_nrst = 1'h0;
  logic [7:0]  i_address;
  logic        i_read, i_write, o_waitrequest, o_irq, o_driver_power_on;
  logic [31:0] i_writedata, o_readdata, q;
  logic [3:0]  o_row_drive, o_col_close, o_col_open;
  logic [3:0]  rm [4];
  integer      fails = 0, checked = 0, seed = 32'h6CC2, n, k;
  initial forever #4 i_clk_sys = ~i_clk_sys;
  host_bus_model host_u (.i_clk_sys, .i_waitrequest(o_waitrequest), .i_readdata(o_readdata), .o_address(i_address),
    .o_read(i_read), .o_write(i_write), .o_writedata(i_writedata));
  relay_command_queue #(.T8_CYC(20), .T2_CYC(5), .T4_CYC(10), .T64_CYC(200)) dut_u (.i_clk_sys, .i_nrst, .i_address,
    .i_read, .i_write, .i_writedata, .o_readdata, .o_waitrequest, .o_irq, .o_row_drive, .o_col_close, .o_col_open,
    .o_driver_power_on);
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task rw(input logic w, input logic [7:0] a, input logic [31:0] v);
    host_u.xfer(w, a, v, q);
  endtask
  task row_op(input logic s, input integer r, input logic [3:0] v);
    rw(1'h0, 8'h00, 32'h0);
    if (q[1] === 1'h0) begin
      rw(1'h1, 8'(8'h10 + 8 * r + (s ? 0 : 4)), {28'h0, v});
      rm[r] = s ? rm[r] | v : rm[r] & v;
      n++;
    end
  endtask
  task settle;
    integer i;
    for (i = 0; i < 1000; i++) begin
      rw(1'h0, 8'h00, 32'h0);
      if (q[0] === 1'h1 && q[3] === 1'h0) break;
    end
  endtask
  task rows;
    integer i;
    for (i = 0; i < 8; i++) begin
      rw(1'h0, 8'(8'h10 + 4 * i), 32'h0);
      cmp(q, {28'h0, rm[i / 2]});
    end
  endtask
  task report_and_stop;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #600000;
    fails++;
    report_and_stop();
  end
  initial begin
    rm = '{default: 4'h0};
    repeat (2) @(posedge i_clk_sys);
    i_nrst <= 1'h1;
    rw(1'h0, 8'h00, 32'h0);
    cmp({o_driver_power_on, q[4:0]}, 6'h01);
    for (k = 0; k < 30; k++) row_op(1'($random(seed)), {$random(seed)} % 4, 4'($random(seed)));
    settle;
    rows;
    rw(1'h1, 8'h04, 32'h0A);
    for (k = 0; k < 4; k++) row_op(1'h0, k, 4'h0);
    settle;
    rw(1'h0, 8'h00, 32'h0);
    cmp({q[2], o_irq, o_driver_power_on}, 3'h7);
    for (k = 0; k < 4; k++) begin
      rw(1'h1, 8'h04, {26'h0, 2'(k), 4'hA});
      // Even rows close 0101, odd rows open 0101 by a reset write of 1010
      row_op(1'(k % 2 == 0), k, (k % 2 == 0) ? 4'h5 : 4'hA);
      n = 0;
      q = 32'h0;
      repeat (220) begin
        @(posedge i_clk_sys);
        if (o_row_drive !== 4'h0) q[7:0] = {o_col_close, o_col_open};
        if (o_row_drive !== 4'h0) n++;
      end
      cmp(n, k == 0 ? 20 : k == 1 ? 5 : k == 2 ? 10 : 200);
      cmp({q[7:0], o_irq}, {((k % 2 == 0) ? 8'h50 : 8'h05), 1'h1});
    end
    n = 0;
    for (k = 0; k < 12; k++) row_op(1'h1, k % 4, 4'($random(seed)));
    cmp(n == 8 || n == 9, 1'h1);
    rw(1'h0, 8'h00, 32'h0);
    cmp(q[1], 1'h1);
    rw(1'h1, 8'h2C, 32'h0);
    settle;
    rows;
    rw(1'h1, 8'h04, 32'h08);
    row_op(1'h1, 0, 4'h1);
    settle;
    cmp(o_irq, 1'h0);
    rw(1'h1, 8'h04, 32'h0C);
    row_op(1'h1, 1, 4'h2);
    cmp(o_driver_power_on, 1'h0);
    settle;
    rw(1'h1, 8'h04, 32'h09);
    rw(1'h1, 8'h10, 32'hF);
    rw(1'h1, 8'h04, 32'h08);
    rw(1'h0, 8'h00, 32'h0);
    cmp(q[2:0], 3'h1);
    rm = '{default: 4'h0};
    rows;
    rw(1'h0, 8'h08, 32'h0);
    cmp(q, 32'h0);
    row_op(1'h1, 2, 4'hF);
    i_nrst <= 1'h0;
    @(posedge i_clk_sys);
    i_nrst <= 1'h1;
    rm = '{default: 4'h0};
    rows;
    report_and_stop();
  end
endmodule // relay_command_queue_tb

// >>> rtl/relay_command_queue.v
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ns
// How it works
// - Queue holds eight row operations
// - Entries drain in order, one interval each
// - Interrupt only after last operation finishes
// - Interrupt on timer expiry with queue empty
// - Readback shows relay states, 1 closed
// - Set write closes only its one bits
// - Reset write opens only its zero bits
// - Set and reset addresses read the same
// - Accepted write updates row and queues
// - Write to full queue is dropped
// - Driver power off after reset
// - Row state cleared by reset
// - Init flag set after initialization
// - Driver power bit gates drivers
// - Interrupt enable gates interrupt
// - Two-bit select picks drive time
// - Self-test keeps drivers unpowered
`include "relay_queue_regs.vh"
module relay_command_queue #(
  parameter DEPTH    = 8,
  parameter T8_CYC   = `RQ_T8MS_US * `RQ_CLK_MHZ,
  parameter T2_CYC   = `RQ_T2MS_US * `RQ_CLK_MHZ,
  parameter T4_CYC   = `RQ_T4MS_US * `RQ_CLK_MHZ,
  parameter T64_CYC  = `RQ_T64MS_US * `RQ_CLK_MHZ
) (
  input  wire        i_clk_sys,
  input  wire        i_nrst,
  input  wire [7:0]  i_address,
  input  wire        i_read,
  input  wire        i_write,
  input  wire [31:0] i_writedata,
  output reg  [31:0] o_readdata,
  output reg         o_waitrequest,
  output reg         o_irq,
  output reg  [3:0]  o_row_drive,
  output reg  [3:0]  o_col_close,
  output reg  [3:0]  o_col_open,
  output reg         o_driver_power_on
);
  localparam ST_IDLE  = 1'b0;
  localparam ST_DRIVE = 1'b1;

  // Entry: row(2), set flag(1), column data(4)
  reg  [6:0]  fifo_mem [0:DEPTH-1];
  reg  [2:0]  wr_ptr_reg;
  reg  [2:0]  rd_ptr_reg;
  reg  [3:0]  count_reg;
  reg  [3:0]  row_state_reg [0:3];
  reg  [5:0]  ctrl_reg;
  reg         init_done_reg;
  reg  [3:0]  init_rows_reg;
  reg         state_reg;
  reg  [6:0]  cur_op_reg;
  reg  [23:0] timer_reg;
  reg         irq_pend_reg;
  reg         ack_reg;
  integer     i;

  wire        soft_rst   = ctrl_reg[`RQ_CT_RST_BIT];
  wire        irq_enable_bit    = ctrl_reg[`RQ_CT_IRQEN_BIT];
  wire        self_test_on      = ctrl_reg[`RQ_CT_SELFTEST_BIT];
  wire        driver_power_on   = ctrl_reg[`RQ_CT_DRVPWR_BIT];
  wire [1:0]  drive_time_select = ctrl_reg[`RQ_CT_TSEL_LSB+1:`RQ_CT_TSEL_LSB];
  wire        q_empty    = (count_reg == 4'h0);
  wire        q_full     = (count_reg == DEPTH[3:0]);
  wire        access     = (i_read | i_write) & ~ack_reg;
  wire        row_hit    = (i_address >= `RQ_ROW_BASE_OFS) && (i_address <= `RQ_ROW_LAST_OFS) &&
                           (i_address[1:0] == 2'b00);
  wire [7:0]  row_off    = i_address - `RQ_ROW_BASE_OFS;
  wire [1:0]  row_idx    = row_off[4:3];
  wire        row_is_set = ~row_off[2];
  wire [3:0]  wdat       = i_writedata[3:0];
  wire        row_wr     = access & i_write & row_hit;
  wire        push       = row_wr & ~q_full & ~soft_rst;
  wire        pop        = (state_reg == ST_IDLE) & ~q_empty;
  wire        expire     = (state_reg == ST_DRIVE) && (timer_reg == 24'h000001);

  // Count for the selected drive time; loaded as is, the interval is exact
  function [23:0] drive_cycles;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   drive_cycles = T8_CYC[23:0];
        2'b01:   drive_cycles = T2_CYC[23:0];
        2'b10:   drive_cycles = T4_CYC[23:0];
        default: drive_cycles = T64_CYC[23:0];
      endcase
    end
  endfunction

  // Bus slave: one wait cycle, answer on the second edge
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_reg       <= 1'b0;
      o_waitrequest <= 1'b1;
      o_readdata    <= 32'h00000000;
    end else begin
      ack_reg       <= access;
      o_waitrequest <= ~access;
      if (access & i_read) begin
        if (i_address == `RQ_STATUS_OFS)
          o_readdata <= {27'h0000000, irq_pend_reg, (state_reg == ST_DRIVE), init_done_reg,
                         q_full, q_empty};
        else if (i_address == `RQ_CTRL_OFS)
          o_readdata <= {26'h0000000, ctrl_reg};
        else if (row_hit)
          o_readdata <= {28'h0000000, row_state_reg[row_idx]};
        else
          o_readdata <= 32'h00000000;
      end
    end
  end

  // Control register; soft reset bit stays set until software clears it
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_reg <= `RQ_CTRL_RESET;
    end else if (access & i_write & (i_address == `RQ_CTRL_OFS)) begin
      ctrl_reg <= i_writedata[5:0];
    end
  end

  // Row state, queue and init tracking
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      for (i = 0; i < 4; i = i + 1)
        row_state_reg[i] <= 4'h0;
      wr_ptr_reg    <= 3'h0;
      init_done_reg <= 1'b0;
      init_rows_reg <= 4'h0;
    end else if (soft_rst) begin
      for (i = 0; i < 4; i = i + 1)
        row_state_reg[i] <= 4'h0;
      wr_ptr_reg    <= 3'h0;
      init_done_reg <= 1'b0;
      init_rows_reg <= 4'h0;
    end else if (push) begin
      if (row_is_set)
        row_state_reg[row_idx] <= row_state_reg[row_idx] | wdat;
      else
        row_state_reg[row_idx] <= row_state_reg[row_idx] & wdat;
      fifo_mem[wr_ptr_reg] <= {row_idx, row_is_set, wdat};
      wr_ptr_reg           <= wr_ptr_reg + 3'h1;
      // Init counts only zero reset writes made with drivers powered
      if (!row_is_set && wdat == 4'h0 && driver_power_on && !self_test_on) begin
        init_rows_reg[row_idx] <= 1'b1;
        if ((init_rows_reg | (4'h1 << row_idx)) == 4'hF)
          init_done_reg <= 1'b1;
      end
    end
  end

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      count_reg <= 4'h0;
    end else if (soft_rst) begin
      count_reg <= 4'h0;
    end else begin
      count_reg <= count_reg + {3'h0, push} - {3'h0, pop};
    end
  end

  // Drive sequencer: one entry per drive interval
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg    <= ST_IDLE;
      rd_ptr_reg   <= 3'h0;
      cur_op_reg   <= 7'h00;
      timer_reg    <= 24'h000000;
      irq_pend_reg <= 1'b0;
    end else if (soft_rst) begin
      state_reg    <= ST_IDLE;
      rd_ptr_reg   <= 3'h0;
      timer_reg    <= 24'h000000;
      irq_pend_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (pop) begin
            cur_op_reg <= fifo_mem[rd_ptr_reg];
            rd_ptr_reg <= rd_ptr_reg + 3'h1;
            timer_reg  <= drive_cycles(drive_time_select);
            state_reg  <= ST_DRIVE;
          end
        end
        ST_DRIVE: begin
          timer_reg <= timer_reg - 24'h000001;
          if (expire) begin
            state_reg <= ST_IDLE;
            // Pending until the next push or a soft reset clears it; a push in the expiry cycle cancels it
            if (q_empty & ~push)
              irq_pend_reg <= 1'b1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      if (push)
        irq_pend_reg <= 1'b0;
    end
  end

  // Drivers; self-test or power off keeps every relay still
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_row_drive       <= 4'h0;
      o_col_close       <= 4'h0;
      o_col_open        <= 4'h0;
      o_driver_power_on <= 1'b0;
      o_irq             <= 1'b0;
    end else begin
      o_driver_power_on <= driver_power_on & ~self_test_on & ~soft_rst;
      o_irq             <= irq_pend_reg & irq_enable_bit & ~soft_rst;
      if ((state_reg == ST_DRIVE) && driver_power_on && !self_test_on && !soft_rst) begin
        o_row_drive <= 4'h1 << cur_op_reg[6:5];
        o_col_close <= cur_op_reg[4] ? cur_op_reg[3:0] : 4'h0;
        o_col_open  <= cur_op_reg[4] ? 4'h0 : ~cur_op_reg[3:0];
      end else begin
        o_row_drive <= 4'h0;
        o_col_close <= 4'h0;
        o_col_open  <= 4'h0;
      end
    end
  end
endmodule // relay_command_queue

// >>> rtl/relay_queue_regs.vh
`ifndef RELAY_QUEUE_REGS_VH
`define RELAY_QUEUE_REGS_VH
// Byte offsets on the Avalon word bus
`define RQ_STATUS_OFS      8'h00
`define RQ_CTRL_OFS        8'h04
`define RQ_ROW_BASE_OFS    8'h10
`define RQ_ROW_LAST_OFS    8'h2C
// Status fields
`define RQ_ST_EMPTY_BIT    0
`define RQ_ST_FULL_BIT     1
`define RQ_ST_INIT_BIT     2
`define RQ_ST_BUSY_BIT     3
`define RQ_ST_IRQ_BIT      4
// Control fields
`define RQ_CT_RST_BIT      0
`define RQ_CT_IRQEN_BIT    1
`define RQ_CT_SELFTEST_BIT 2
`define RQ_CT_DRVPWR_BIT   3
`define RQ_CT_TSEL_LSB     4
`define RQ_CTRL_RESET      6'h00
// Drive times in microseconds
`define RQ_T8MS_US         8000
`define RQ_T2MS_US         2000
`define RQ_T4MS_US         4000
`define RQ_T64MS_US        64000
`define RQ_CLK_MHZ         125
`endif
